// ---- design/fss_pkg.sv ----
// constants, field layouts and carrier types for the scan and seek engine
// assumes a 125 MHz controller clock and an 8-bit register port
package fss_pkg;
	// clock and timing
	localparam int          CLK_MHZ         = 125;
	localparam int          CLK_KHZ         = 125000;
	localparam int          SRT_UNIT_MS     = 1;
	localparam int          SRT_UNIT_CYC    = SRT_UNIT_MS * CLK_KHZ;
	localparam int          FM_LIMIT_US     = 27;
	localparam int          MFM_LIMIT_US    = 13;
	localparam logic [11:0] FM_LIMIT_CYC    = 12'(FM_LIMIT_US * CLK_MHZ);
	localparam logic [11:0] MFM_LIMIT_CYC   = 12'(MFM_LIMIT_US * CLK_MHZ);
	localparam logic [2:0]  STEP_PW_CYC     = 3'h7;
	localparam logic [4:0]  SRT_BASE        = 5'h10;
	localparam logic [6:0]  RECAL_MAX_STEPS = 7'h4D;
	// register addresses
	localparam logic [3:0]  A_CFG  = 4'h0;
	localparam logic [3:0]  A_SRT  = 4'h1;
	localparam logic [3:0]  A_STEP = 4'h2;
	localparam logic [3:0]  A_EOT  = 4'h3;
	localparam logic [3:0]  A_SEC  = 4'h4;
	localparam logic [3:0]  A_NCN  = 4'h5;
	localparam logic [3:0]  A_CMD  = 4'h6;
	localparam logic [3:0]  A_DATA = 4'h7;
	localparam logic [3:0]  A_ST0  = 4'h8;
	localparam logic [3:0]  A_ST1  = 4'h9;
	localparam logic [3:0]  A_ST2  = 4'hA;
	localparam logic [3:0]  A_PCN  = 4'hB;
	localparam logic [3:0]  A_MSR  = 4'hC;
	// field positions
	localparam int          CFG_SKIP  = 2;
	localparam int          CFG_MFM   = 3;
	localparam int          CFG_ND    = 4;
	localparam int          ST1_OR    = 4;
	localparam int          ST2_CM    = 6;
	localparam int          ST2_SH    = 3;
	localparam int          ST2_SN    = 2;
	localparam logic [7:0]  ST0_INVALID = 8'h80;
	localparam logic [7:0]  RESET_BYTE  = 8'h00;
	// command opcodes, upper nibble of a command write
	localparam logic [3:0]  OP_SEEK  = 4'h1;
	localparam logic [3:0]  OP_RECAL = 4'h2;
	localparam logic [3:0]  OP_SCAN  = 4'h3;
	localparam logic [3:0]  OP_SENSE = 4'h4;
	// interrupt codes, status 0 bits 7:6
	localparam logic [1:0]  IC_NORMAL = 2'h0;
	localparam logic [1:0]  IC_ABN    = 2'h1;
	localparam logic [1:0]  IC_RDYCHG = 2'h3;

	typedef enum logic [1:0] {SCAN_EQ, SCAN_LE, SCAN_GE} fss_scan_t;
	typedef enum logic [1:0] {SS_IDLE, SS_FIND, SS_DATA} fss_sst_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} fss_bus_t;

	typedef struct packed {
		logic       bvalid;
		logic [7:0] bdata;
		logic       sstart;
		logic [7:0] snum;
		logic       sdel;
		logic       send;
	} fss_disk_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} fss_dma_t;
endpackage

// ---- design/fss_core.sv ----
// scan compare, seek and recalibrate stepping, and interrupt sources
// assumes a read channel on MCLK delivering sector events and bytes,
// drive status pins from outside the clock domain, one MCLK and RSTN
`timescale 1ns/10ps
module fss_core #(
	parameter int MS_CYCLES = fss_pkg::SRT_UNIT_CYC
) (
	// clock and reset
	input  wire  logic              MCLK,
	input  wire  logic              RSTN,
	// register port
	input  wire  fss_pkg::fss_bus_t RBUS,
	output logic [7:0]              RDATA,
	// read channel and dma
	input  wire  fss_pkg::fss_disk_t DISK,
	input  wire  fss_pkg::fss_dma_t  DMA,
	output logic                    DMA_REQ,
	// drive pins
	input  wire  logic [3:0]        READY,
	input  wire  logic [3:0]        TRK0,
	input  wire  logic              INDEX,
	input  wire  logic              TC,
	output logic [3:0]              STEP,
	output logic [3:0]              DIR,
	// host status
	output logic                    INT,
	output logic                    BUSY
);
	import fss_pkg::*;

	localparam int MSW = $clog2(MS_CYCLES + 1);

	typedef struct packed {
		logic [9:0]      s1, s2, s3, flt;
		logic [MSW-1:0]  ms_cnt;
		fss_scan_t       mode;
		logic            skip, mfm, nd;
		logic [3:0]      step_rate_time;
		logic [7:0]      stepv, last_sector_number, sec, new_cylinder, rdata;
		logic [3:0]      dact, drecal, ddir, dstep, pend;
		logic [3:0][7:0] present_cylinder, tgt;
		logic [3:0][4:0] wait_ms, pcode;
		logic [3:0][2:0] pw;
		logic [3:0][6:0] nsteps;
		fss_sst_t        sst;
		logic            last, hok, req, dreq, tcseen, idx1, eq, le, ge;
		logic [7:0]      hbyte;
		logic [11:0]     dl;
		logic [1:0]      drv;
		logic [7:0]      st0, st1, st2, pcnres;
		logic            res, res_int, busy, cmdb, intr;
	} fss_state_t;

	fss_state_t q, n;
	logic       ms_tick;
	logic [9:0] edge_v;
	logic [11:0] lim;

	// scan termination: status 0, result phase, request dropped
	function automatic fss_state_t fin(input fss_state_t s, input logic [1:0] ic);
		fss_state_t r;
		r = s;
		r.sst = SS_IDLE;
		r.st0 = {ic, 3'h0, 1'b0, s.drv};
		r.res = 1'b1;
		r.res_int = 1'b1;
		r.req = 1'b0;
		return r;
	endfunction

	// next state
	always_comb begin
		logic [3:0] op;
		logic       wr_cmd, hin, met, found;
		logic [7:0] db;
		n = q;
		op = RBUS.wdata[7:4];
		wr_cmd = RBUS.wr && RBUS.addr == A_CMD;
		hin = 1'b0;
		met = 1'b0;
		found = 1'b0;
		db = DISK.bdata;
		// three-stage sync, a bit changes once stages two and three agree
		n.s1 = {TC, INDEX, TRK0, READY};
		n.s2 = q.s1;
		n.s3 = q.s2;
		n.flt = (q.flt & (q.s2 ^ q.s3)) | (q.s3 & ~(q.s2 ^ q.s3));
		edge_v = n.flt ^ q.flt;
		// millisecond enable, period must exceed the step pulse width
		ms_tick = q.ms_cnt == MSW'(MS_CYCLES - 1);
		n.ms_cnt = ms_tick ? '0 : q.ms_cnt + 1'b1;
		lim = q.mfm ? MFM_LIMIT_CYC : FM_LIMIT_CYC;
		n.cmdb = 1'b0;
		// read side: data in the cycle after the strobe only
		n.rdata = RESET_BYTE;
		if (RBUS.rd) begin
			case (RBUS.addr)
				A_CFG:   n.rdata = {3'h0, q.nd, q.mfm, q.skip, q.mode};
				A_SRT:   n.rdata = {4'h0, q.step_rate_time};
				A_STEP:  n.rdata = q.stepv;
				A_EOT:   n.rdata = q.last_sector_number;
				A_SEC:   n.rdata = q.sec;
				A_NCN:   n.rdata = q.new_cylinder;
				A_DATA:  n.rdata = q.hbyte;
				A_ST0:   n.rdata = q.st0;
				A_ST1:   n.rdata = q.st1;
				A_ST2:   n.rdata = q.st2;
				A_PCN:   n.rdata = q.pcnres;
				A_MSR:   n.rdata = {2'h0, q.res, q.busy, q.dact};
				default: n.rdata = RESET_BYTE;
			endcase
			if (RBUS.addr == A_ST0) begin
				n.res = 1'b0;
				n.res_int = 1'b0;
			end
		end
		// plain setting writes
		if (RBUS.wr) begin
			case (RBUS.addr)
				A_CFG: begin
					n.mode = fss_scan_t'(RBUS.wdata[1:0]);
					n.skip = RBUS.wdata[CFG_SKIP];
					n.mfm  = RBUS.wdata[CFG_MFM];
					n.nd   = RBUS.wdata[CFG_ND];
				end
				A_SRT:   n.step_rate_time = RBUS.wdata[3:0];
				A_STEP:  n.stepv = RBUS.wdata;
				A_EOT:   n.last_sector_number = RBUS.wdata;
				A_SEC:   n.sec = RBUS.wdata;
				A_NCN:   n.new_cylinder = RBUS.wdata;
				A_DATA:  hin = q.nd;
				default: ;
			endcase
		end
		if (!q.nd && DMA.valid)
			hin = 1'b1;
		// commands; any pending drive interrupt (seek end, not ready or ready change) makes anything but sense invalid
		if (wr_cmd) begin
			if (|q.pend && op != OP_SENSE) begin
				n.st0 = ST0_INVALID;
				n.res = 1'b1;
				n.res_int = 1'b0;
			end else if (op == OP_SENSE) begin
				n.st0 = ST0_INVALID;
				for (int i = 3; i >= 0; i--) begin
					if (q.pend[i]) begin
						n.st0 = {q.pcode[i], 1'b0, 2'(i)};
						n.pcnres = q.present_cylinder[i];
						found = 1'b1;
					end
				end
				for (int i = 0; i < 4; i++) begin
					if (found && n.st0[1:0] == 2'(i))
						n.pend[i] = 1'b0;
				end
				n.res = 1'b1;
				n.res_int = 1'b0;
			end else if ((op == OP_SEEK || op == OP_RECAL) && !q.dact[RBUS.wdata[1:0]]) begin
				n.dact[RBUS.wdata[1:0]] = 1'b1;
				n.drecal[RBUS.wdata[1:0]] = op == OP_RECAL;
				n.tgt[RBUS.wdata[1:0]] = q.new_cylinder;
				n.wait_ms[RBUS.wdata[1:0]] = 5'h00;
				n.nsteps[RBUS.wdata[1:0]] = 7'h00;
				if (op == OP_RECAL)
					n.present_cylinder[RBUS.wdata[1:0]] = 8'h00;
				n.cmdb = 1'b1;
			end else if (op == OP_SCAN && q.sst == SS_IDLE) begin
				n.sst = SS_FIND;
				n.drv = RBUS.wdata[1:0];
				n.st1 = RESET_BYTE;
				n.st2 = RESET_BYTE;
				n.tcseen = 1'b0;
				n.idx1 = 1'b0;
				n.hok = 1'b0;
				n.req = 1'b0;
			end
		end
		// per-drive stepping engines, running side by side
		for (int i = 0; i < 4; i++) begin
			if (q.pw[i] != 3'h0)
				n.pw[i] = q.pw[i] - 3'h1;
			if (q.dact[i] && !q.flt[i]) begin
				n.dact[i] = 1'b0;
				n.pend[i] = 1'b1;
				n.pcode[i] = {IC_ABN, 3'b001};
			end else if (q.dact[i] && q.pw[i] == 3'h0) begin
				// decide only on a divider tick so every interval is whole ms
				if (q.wait_ms[i] != 5'h00 || !ms_tick) begin
					if (ms_tick)
						n.wait_ms[i] = q.wait_ms[i] - 5'h01;
				end else if (q.drecal[i] && q.flt[4+i]) begin
					n.dact[i] = 1'b0;
					n.pend[i] = 1'b1;
					n.pcode[i] = {IC_NORMAL, 3'b100};
				end else if (q.drecal[i] && q.nsteps[i] == RECAL_MAX_STEPS) begin
					n.dact[i] = 1'b0;
					n.pend[i] = 1'b1;
					n.pcode[i] = {IC_ABN, 3'b110};
				end else if (!q.drecal[i] && q.present_cylinder[i] == q.tgt[i]) begin
					n.dact[i] = 1'b0;
					n.pend[i] = 1'b1;
					n.pcode[i] = {IC_NORMAL, 3'b100};
				end else begin
					n.pw[i] = STEP_PW_CYC;
					n.wait_ms[i] = SRT_BASE - {1'b0, q.step_rate_time} - 5'h01;
					if (q.drecal[i]) begin
						n.ddir[i] = 1'b1;
						n.nsteps[i] = q.nsteps[i] + 7'h01;
					end else if (q.present_cylinder[i] < q.tgt[i]) begin
						n.ddir[i] = 1'b1;
						n.present_cylinder[i] = q.present_cylinder[i] + 8'h01;
					end else begin
						n.ddir[i] = 1'b0;
						n.present_cylinder[i] = q.present_cylinder[i] - 8'h01;
					end
				end
			end else if (!q.dact[i] && !q.pend[i] && edge_v[i]) begin
				n.pend[i] = 1'b1;
				n.pcode[i] = {IC_RDYCHG, 3'b000};
			end
			n.dstep[i] = n.pw[i] != 3'h0;
		end
		// scan engine
		if (q.sst != SS_IDLE) begin
			if (q.flt[9])
				n.tcseen = 1'b1;
			if (hin && q.req) begin
				n.hbyte = q.nd ? RBUS.wdata : DMA.data;
				n.hok = 1'b1;
				n.req = 1'b0;
			end
			if (q.req)
				n.dl = q.dl + 12'h001;
			if (edge_v[8] && n.flt[8]) begin
				n.idx1 = 1'b1;
				if (q.idx1)
					n = fin(n, IC_ABN);
			end
		end
		if (q.sst == SS_FIND) begin
			if (q.tcseen || q.flt[9])
				n = fin(n, IC_NORMAL);
			else if (DISK.sstart && DISK.snum == q.sec) begin
				if (DISK.sdel)
					n.st2[ST2_CM] = 1'b1;
				if (DISK.sdel && q.skip) begin
					n.st2[ST2_CM] = 1'b1;
					if (q.sec == q.last_sector_number) begin
						n.st2[ST2_SN] = 1'b1;
						n = fin(n, IC_NORMAL);
					end else
						n.sec = q.sec + q.stepv;
				end else begin
					n.sst = SS_DATA;
					n.last = DISK.sdel || q.sec == q.last_sector_number;
					n.eq = 1'b1;
					n.le = 1'b1;
					n.ge = 1'b1;
					n.req = 1'b1;
					n.hok = 1'b0;
					n.dl = 12'h000;
				end
			end
		end else if (q.sst == SS_DATA) begin
			if (DISK.bvalid) begin
				if (!q.hok) begin
					n.st1[ST1_OR] = 1'b1;
					n = fin(n, IC_ABN);
				end else begin
					n.eq = q.eq && db == q.hbyte;
					n.le = q.le && db <= q.hbyte;
					n.ge = q.ge && db >= q.hbyte;
					n.hok = 1'b0;
					n.req = 1'b1;
					n.dl = 12'h000;
					if (q.tcseen || q.flt[9])
						n = fin(n, IC_NORMAL);
				end
			end else if (DISK.send) begin
				case (q.mode)
					SCAN_EQ: met = q.eq;
					SCAN_LE: met = q.le;
					SCAN_GE: met = q.ge;
					default: met = 1'b0;
				endcase
				if (met) begin
					n.st2[ST2_SH] = 1'b1;
					n = fin(n, IC_NORMAL);
				end else if (q.last) begin
					n.st2[ST2_SN] = 1'b1;
					n = fin(n, IC_NORMAL);
				end else begin
					n.sec = q.sec + q.stepv;
					n.sst = SS_FIND;
					n.req = 1'b0;
					n.hok = 1'b0;
				end
			end else if (q.flt[9] && !q.hok)
				n = fin(n, IC_NORMAL);
			if (q.req && q.dl == lim) begin
				n.st1[ST1_OR] = 1'b1;
				n = fin(n, IC_ABN);
			end
		end
		// outputs
		n.busy = n.cmdb || n.sst != SS_IDLE;
		n.dreq = n.req && !n.nd;
		n.intr = (n.res && n.res_int) || |n.pend || (n.req && n.nd);
	end

	// state register
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN)
			q <= '0;
		else
			q <= n;
	end

	assign RDATA   = q.rdata;
	assign DMA_REQ = q.dreq;
	assign STEP    = q.dstep;
	assign DIR     = q.ddir;
	assign INT     = q.intr;
	assign BUSY    = q.busy;

	// checks on drive 0, the seek busy pulse, the result interrupt and the scan engine
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RSTN);

	sequence step_rise_s;
		$rose(q.dstep[0]);
	endsequence
	sequence seek_done_s;
		$fell(q.dact[0]) && !q.drecal[0] && !q.pcode[0][0];
	endsequence
	sequence seek_cmd_s;
		RBUS.wr && RBUS.addr == A_CMD && RBUS.wdata[7:4] == OP_SEEK
			&& q.sst == SS_IDLE && !(|q.pend) && !q.dact[RBUS.wdata[1:0]];
	endsequence

	step_dir_a: assert property (step_rise_s and (q.dact[0] && !q.drecal[0])
		|-> q.ddir[0] == ($past(q.present_cylinder[0]) < q.tgt[0]))
		else $error("step direction does not follow cylinder order");
	step_rate_a: assert property (step_rise_s |-> q.wait_ms[0] == SRT_BASE - {1'b0, q.step_rate_time} - 5'h01)
		else $error("step interval not taken from rate code");
	step_width_a: assert property (step_rise_s |-> q.dstep[0] [*7] ##1 !q.dstep[0])
		else $error("step pulse width wrong");
	seek_end_a: assert property (seek_done_s |-> q.present_cylinder[0] == q.tgt[0] && q.pcode[0][2])
		else $error("seek ended away from target");
	not_ready_a: assert property (q.dact[0] && !q.flt[0] |=> !q.dact[0] && q.pend[0]
		&& q.pcode[0][0])
		else $error("not ready did not end the seek");
	recal_limit_a: assert property ($fell(q.dact[0]) && q.drecal[0] && q.pcode[0][1]
		|-> q.nsteps[0] == RECAL_MAX_STEPS && q.pcode[0][2])
		else $error("equipment check before step limit");
	busy_pulse_a: assert property (seek_cmd_s |=> BUSY ##1 (!BUSY || q.sst != SS_IDLE))
		else $error("busy held through seek execution");
	scan_hit_a: assert property ($rose(q.st2[ST2_SH]) |-> q.sst == SS_IDLE && INT)
		else $error("scan hit did not end the command");
	scan_miss_a: assert property ($rose(q.st2[ST2_SN]) |-> q.sst == SS_IDLE
		&& !q.st2[ST2_SH])
		else $error("not satisfied without termination");
	overrun_a: assert property (q.sst == SS_DATA && q.req && q.dl == lim
		|=> q.st1[ST1_OR] && q.sst == SS_IDLE)
		else $error("late byte did not raise overrun");
	int_hold_a: assert property (q.res && q.res_int && !(RBUS.rd && RBUS.addr == A_ST0)
		|=> INT)
		else $error("result interrupt dropped early");
endmodule // fss_core

// ---- tb/fss_drv_model.sv ----
// drive side partner: track zero switches and dma byte supply
// assumes step pulses on MCLK and the bench setting levels and bytes
`timescale 1ns/10ps
module fss_drv_model (
	// clock and reset
	input  wire logic              MCLK,
	input  wire logic              RSTN,
	// engine side
	input  wire logic [3:0]        STEP,
	input  wire logic              DMA_REQ,
	output fss_pkg::fss_dma_t      DMA,
	output logic [3:0]             TRK0,
	// bench control
	input  wire logic [7:0]        trk0_at,
	input  wire logic              clr,
	input  wire logic              dma_en,
	input  wire logic [7:0]        dma_byte
);
	import fss_pkg::*;
	logic [7:0] cnt [4];
	logic [3:0] step_d;
	logic       given;
	logic       req_d;
	logic       give;
	// answer one cycle after the request so the bench byte has settled
	assign give = dma_en && DMA_REQ && req_d && !given;
	// count step pulses per drive, supply one byte per request
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			step_d <= 4'h0;
			given <= 1'b0;
			req_d <= 1'b0;
			DMA <= '0;
			for (int i = 0; i < 4; i++) cnt[i] <= 8'h00;
		end else begin
			step_d <= STEP;
			for (int i = 0; i < 4; i++) begin
				if (clr) cnt[i] <= 8'h00;
				else if (STEP[i] && !step_d[i]) cnt[i] <= cnt[i] + 8'h01;
			end
			req_d <= DMA_REQ;
			DMA.valid <= give;
			// released data toggles so a stale byte never matches
			DMA.data <= give ? dma_byte : ~DMA.data;
			given <= DMA_REQ && (given || give);
		end
	end
	// track zero switch closes after the armed number of steps
	always_comb begin
		for (int i = 0; i < 4; i++) TRK0[i] = cnt[i] >= trk0_at;
	end
endmodule // fss_drv_model

// ---- tb/tb_floppy_scan_seek_control.sv ----
// self-checking bench for the scan, seek and interrupt engine
// assumes fss_core and the drive model; ms tick shortened to 20 cycles
`timescale 1ns/10ps
module tb_floppy_scan_seek_control;
	import fss_pkg::*;
	localparam int MS = 20;
	logic mclk = 1'b0, rstn, DMA_REQ, INT, BUSY, INDEX, TC, clr, dma_en, dir0, s0p = 1'b0;
	logic [3:0] READY, TRK0, STEP, DIR;
	logic [7:0] RDATA, dbyte, trk0_at, v, lf = 8'h07;
	fss_bus_t   rb;
	fss_disk_t  dk;
	fss_dma_t   dma;
	int failures = 0, checks_done = 0, nst = 0, gap = 0, gmin = 999;
	fss_core #(.MS_CYCLES(MS)) u_dut (.MCLK(mclk), .RSTN(rstn), .RBUS(rb), .RDATA(RDATA),
		.DISK(dk), .DMA(dma), .DMA_REQ(DMA_REQ), .READY(READY), .TRK0(TRK0), .INDEX(INDEX),
		.TC(TC), .STEP(STEP), .DIR(DIR), .INT(INT), .BUSY(BUSY));
	fss_drv_model u_drv (.MCLK(mclk), .RSTN(rstn), .STEP(STEP), .DMA_REQ(DMA_REQ), .DMA(dma),
		.TRK0(TRK0), .trk0_at(trk0_at), .clr(clr), .dma_en(dma_en), .dma_byte(dbyte));
	// clock
	always #4 mclk = ~mclk;
	// drive 0 step monitor: count, spacing, direction
	always @(negedge mclk) begin
		gap++;
		if (STEP[0] && !s0p) begin
			if (nst > 0 && gap < gmin) gmin = gap;
			nst++;
			gap = 0;
			dir0 = DIR[0];
		end
		s0p = STEP[0];
	end
	function automatic logic [7:0] nx(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction
	function automatic logic sat(input logic [1:0] m, input logic [7:0] d, h);
		return m == SCAN_EQ ? d == h : m == SCAN_LE ? d <= h : d >= h;
	endfunction
	function automatic logic sig(input int s);
		return s == 0 ? INT : s == 1 ? DMA_REQ : logic'(nst > 0);
	endfunction
	task automatic end_sim();
		if (failures == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		rb <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk);
		rb <= '0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		rb <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge mclk);
		rb <= '0;
		@(negedge mclk);
		d = RDATA;
		@(posedge mclk);
	endtask
	// bounded wait for a level, a timeout counts as a mismatch
	task automatic wt(input int s, input logic l);
		int n;
		n = 0;
		@(negedge mclk);
		while (sig(s) !== l && n < 5000) begin
			@(negedge mclk);
			n++;
		end
		chk({7'h0, sig(s)}, {7'h0, l});
		@(posedge mclk);
	endtask
	task automatic pls(input fss_disk_t x);
		dk <= x;
		@(posedge mclk);
		dk <= '0;
		@(posedge mclk);
	endtask
	task automatic cmd(input logic [3:0] op, input logic [1:0] d, input logic [7:0] n);
		nst = 0;
		gmin = 999;
		wr(A_NCN, n);
		wr(A_CMD, {op, 2'h0, d});
	endtask
	task automatic sense(input logic [7:0] s0, p, input logic pc);
		wr(A_CMD, {OP_SENSE, 4'h0});
		rd(A_ST0, v);
		chk(v, s0);
		rd(A_PCN, v);
		if (pc) chk(v, p);
	endtask
	task automatic recal(input logic [7:0] at);
		trk0_at <= at;
		clr <= 1'b1;
		@(posedge mclk);
		clr <= 1'b0;
		cmd(OP_RECAL, 2'h0, 8'h00);
		wt(0, 1'b1);
		chk({7'h0, dir0}, 8'h01);
	endtask
	task automatic res(input logic [7:0] s2, input logic [1:0] ic, input logic [7:0] s1);
		wt(0, 1'b1);
		rd(A_ST2, v);
		chk(v, s2);
		rd(A_ST1, v);
		chk(v, s1);
		rd(A_ST0, v);
		chk({6'h0, v[7:6]}, {6'h0, ic});
		@(negedge mclk);
		chk({7'h0, INT}, 8'h00);
		@(posedge mclk);
	endtask
	task automatic scmd(input logic [7:0] cfg, sector_step_value);
		wr(A_CFG, cfg);
		wr(A_STEP, sector_step_value);
		wr(A_EOT, 8'h05);
		wr(A_SEC, 8'h01);
		wr(A_CMD, {OP_SCAN, 4'h0});
	endtask
	// one scan over sectors 1..5, expected flags worked out per sector
	task automatic scan(input logic [1:0] md, input logic sk, nd, input logic [7:0] sector_step_value, dl);
		logic [7:0] r, h, d;
		logic ok, fin, cm, del;
		r = 8'h01;
		fin = 1'b0;
		cm = 1'b0;
		scmd({3'h0, nd, 1'b0, sk, md}, sector_step_value);
		while (!fin) begin
			del = r == dl;
			ok = !(del && sk);
			pls('{1'b0, 8'h00, 1'b1, r, del, 1'b0});
			for (int i = 0; i < 4 && !(del && sk); i++) begin
				lf = nx(lf);
				h = lf;
				lf = nx(lf);
				d = lf[1:0] == 2'h0 ? lf : (lf[1:0] == 2'h1 ? {8{lf[2]}} : h);
				dbyte <= h;
				wt(nd ? 0 : 1, 1'b1);
				if (nd) wr(A_DATA, h);
				else wt(1, 1'b0);
				pls('{1'b1, d, 1'b0, 8'h00, 1'b0, 1'b0});
				ok &= sat(md, d, h);
			end
			pls('{1'b0, 8'h00, 1'b0, 8'h00, 1'b0, 1'b1});
			cm |= del;
			fin = ok || (del && !sk) || r == 8'h05;
			r += sector_step_value;
		end
		res({1'b0, cm, 2'h0, ok, !ok, 2'h0}, IC_NORMAL, 8'h00);
	endtask
	initial begin
		repeat (60000) @(posedge mclk);
		failures++;
		end_sim();
	end
	initial begin
		rstn = 1'b0;
		rb = '0;
		dk = '0;
		READY = 4'h0;
		INDEX = 1'b0;
		TC = 1'b0;
		clr = 1'b0;
		dma_en = 1'b1;
		dbyte = 8'h00;
		trk0_at = 8'hFF;
		repeat (5) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		rd(4'hF, v);
		chk(v, 8'h00);
		READY <= 4'hB;
		wt(0, 1'b1);
		sense(8'hC0, 8'h00, 1'b1);
		sense(8'hC1, 8'h00, 1'b1);
		sense(8'hC3, 8'h00, 1'b1);
		chk({7'h0, INT}, 8'h00);
		wr(A_SRT, 8'h0E);
		cmd(OP_SEEK, 2'h0, 8'h03);
		wt(2, 1'b1);
		chk({7'h0, BUSY}, 8'h00);
		wt(0, 1'b1);
		chk(8'(nst), 8'h03);
		chk({7'h0, dir0}, 8'h01);
		chk(8'(gmin), 8'(2 * MS));
		sense(8'h20, 8'h03, 1'b1);
		cmd(OP_SEEK, 2'h0, 8'h01);
		wt(0, 1'b1);
		chk({7'h0, dir0}, 8'h00);
		sense(8'h20, 8'h01, 1'b1);
		cmd(OP_SEEK, 2'h0, 8'h02);
		wt(0, 1'b1);
		cmd(OP_SEEK, 2'h0, 8'h04);
		rd(A_ST0, v);
		chk(v, ST0_INVALID);
		sense(8'h20, 8'h02, 1'b1);
		cmd(OP_SEEK, 2'h0, 8'h04);
		cmd(OP_SEEK, 2'h1, 8'h03);
		wt(0, 1'b1);
		sense(8'h20, 8'h04, 1'b1);
		wt(0, 1'b1);
		sense(8'h21, 8'h03, 1'b1);
		cmd(OP_SEEK, 2'h2, 8'h03);
		wt(0, 1'b1);
		sense(8'h4A, 8'h00, 1'b1);
		wr(A_SRT, 8'h0F);
		recal(8'h04);
		chk(8'(nst), 8'h04);
		chk(8'(gmin), 8'(MS));
		sense(8'h20, 8'h00, 1'b1);
		recal(8'hFF);
		chk(8'(nst), 8'h4D);
		sense(8'h70, 8'h00, 1'b0);
		for (int k = 0; k < 6; k++)
			scan(2'(k % 3), k[0], k == 5, k < 3 ? 8'h01 : 8'h02, k == 1 ? 8'h02 : (k == 4 ? 8'h03 : 8'h00));
		dma_en <= 1'b0;
		scmd(8'h00, 8'h01);
		pls('{1'b0, 8'h00, 1'b1, 8'h01, 1'b0, 1'b0});
		wt(1, 1'b1);
		TC <= 1'b1;
		repeat (6) @(posedge mclk);
		TC <= 1'b0;
		res(8'h00, IC_NORMAL, 8'h00);
		scmd(8'h01, 8'h01);
		pls('{1'b0, 8'h00, 1'b1, 8'h01, 1'b0, 1'b0});
		wt(1, 1'b1);
		pls('{1'b1, 8'h5A, 1'b0, 8'h00, 1'b0, 1'b0});
		res(8'h00, IC_ABN, 8'h10);
		dma_en <= 1'b1;
		scmd(8'h02, 8'h01);
		repeat (2) begin
			INDEX <= 1'b1;
			repeat (6) @(posedge mclk);
			INDEX <= 1'b0;
			repeat (6) @(posedge mclk);
		end
		res(8'h00, IC_ABN, 8'h00);
		// terminal count while a byte is held: that byte is compared first
		scmd(8'h00, 8'h01);
		pls('{1'b0, 8'h00, 1'b1, 8'h01, 1'b0, 1'b0});
		wt(1, 1'b1);
		wt(1, 1'b0);
		TC <= 1'b1;
		repeat (6) @(posedge mclk);
		chk({7'h0, INT}, 8'h00);
		pls('{1'b1, 8'h5A, 1'b0, 8'h00, 1'b0, 1'b0});
		TC <= 1'b0;
		res(8'h00, IC_NORMAL, 8'h00);
		end_sim();
	end
endmodule // tb_floppy_scan_seek_control
